/* design/ssp_spi_pkg.sv */
// Package: register map, field positions, modes and timing for the SPI port
package ssp_spi_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte addresses on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_STATUS   = 3'h0;
   localparam logic [2:0] ADDR_CONTROL1 = 3'h1;
   localparam logic [2:0] ADDR_CONTROL3 = 3'h2;
   localparam logic [2:0] ADDR_DATA     = 3'h3;
   localparam logic [2:0] ADDR_BAUD     = 3'h4;
   localparam logic [2:0] ADDR_IRQ      = 3'h5;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STAT_SMP_BIT  = 7;
   localparam int STAT_CKE_BIT  = 6;
   localparam int STAT_STOP_BIT = 4;
   localparam int STAT_BF_BIT   = 0;
   localparam int CON1_WRITE_COLLISION_FLAG_BIT = 7;
   localparam int CON1_OV_BIT   = 6;
   localparam int CON1_EN_BIT   = 5;
   localparam int CON1_CKP_BIT  = 4;
   localparam int CON3_BUFFER_OVERWRITE_ENABLE_BIT = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_STATUS   = 8'h00;
   localparam logic [7:0] RST_CONTROL1 = 8'h00;
   localparam logic [7:0] RST_CONTROL3 = 8'h00;
   localparam logic [7:0] RST_BAUD     = 8'h01;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_DIV4    = 4'h0;
   localparam logic [3:0] MODE_DIV16   = 4'h1;
   localparam logic [3:0] MODE_DIV64   = 4'h2;
   localparam logic [3:0] MODE_TIMER   = 4'h3;
   localparam logic [3:0] MODE_SLV_SEL = 4'h4;
   localparam logic [3:0] MODE_SLV     = 4'h5;
   localparam logic [3:0] MODE_BAUD    = 4'hA;

   // Half bit periods in core cycles for the fixed master rates
   localparam logic [8:0] HALF_DIV4  = 9'h002;
   localparam logic [8:0] HALF_DIV16 = 9'h008;
   localparam logic [8:0] HALF_DIV64 = 9'h020;

   typedef enum logic {ROLE_MASTER, ROLE_SLAVE} role_t;

   // Pin bundle toward the serial pins
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } spi_pins_t;

endpackage : ssp_spi_pkg

/* design/ssp_pin_sync.sv */
// Three-stage input synchroniser for pins entering the core clock domain
module ssp_pin_sync
   import ssp_spi_pkg::*;
(
   input  wire logic i_core_clk,
   input  wire logic i_rstn,
   input  wire logic i_pin,
   output logic      o_level
);

   logic s1;
   logic s2;
   logic s3;

   // A change counts once the second and third stages agree
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         s1      <= 1'b0;
         s2      <= 1'b0;
         s3      <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end

endmodule : ssp_pin_sync

/* design/ssp_rate_gen.sv */
// Master bit-rate divider giving one-cycle half-bit enable pulses
module ssp_rate_gen
   import ssp_spi_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_run,
   input  wire logic [3:0] i_mode,
   input  wire logic [7:0] i_baud,
   input  wire logic       i_timer_tick,
   output logic            o_half_tick
);

   logic [8:0] cnt;
   logic [8:0] half;
   logic       use_timer;

   always_comb begin
      use_timer = 1'b0;
      case (i_mode)
         MODE_DIV16: half = HALF_DIV16;
         MODE_DIV64: half = HALF_DIV64;
         // Fosc/(4*(n+1)): half bit is 2*(n+1) core cycles
         MODE_BAUD:  half = {i_baud, 1'b0} + 9'h002;
         MODE_TIMER: begin
            half      = HALF_DIV4;
            use_timer = 1'b1;
         end
         default:    half = HALF_DIV4;
      endcase
   end

   // Timer output divided by two: each timer tick is one half bit
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         cnt         <= 9'h000;
         o_half_tick <= 1'b0;
      end else if (!i_run) begin
         cnt         <= 9'h000;
         o_half_tick <= 1'b0;
      end else if (use_timer) begin
         o_half_tick <= i_timer_tick;
      end else if (cnt >= half - 9'h001) begin
         cnt         <= 9'h000;
         o_half_tick <= 1'b1;
      end else begin
         cnt         <= cnt + 9'h001;
         o_half_tick <= 1'b0;
      end
   end

endmodule : ssp_rate_gen

/* design/ssp_spi.sv */
// SPI-mode synchronous serial port: registers, master and slave engines
// Behaviour
// [RULE_01] Master samples end or middle per phase bit
// [RULE_02] Software keeps sample phase zero as slave
// [RULE_03] Edge select picks output change transition
// [RULE_04] Polarity bit sets serial clock idle level
// [RULE_05] Byte arrival sets full; data read clears
// [RULE_06] Busy data write dropped, collision flag set
// [RULE_07] Slave unread buffer overflow sets flag, keeps
// [RULE_08] Overflow flag never set in master mode
// [RULE_09] Enable bit hands pins to the port
// [RULE_10] Stop status reads zero while disabled
// [RULE_11] Mode field picks master clock rate
// [RULE_12] Modes 0100/0101 slave with/without select
// [RULE_13] Software never programs divider to zero
// [RULE_14] Software uses only listed mode encodings
// [RULE_15] Overwrite enable always loads new byte
// [RULE_16] Overwrite still flags overflow when full
// [RULE_17] MSb first; eight bits load buffer, flags (a master sampling on the trailing edge runs nine clocks per byte)
// [RULE_18] Shift register reached only via data buffer
// [RULE_19] Slave software reads every received byte
// [RULE_20] Data write loads buffer and shift register
// [RULE_21] Master starts shifting on data write
// [RULE_22] Select high floats output, clears count
//
// Chosen here: the strobed register port and the register addresses.
module ssp_spi
   import ssp_spi_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   input  wire logic       i_timer_tick,
   input  wire logic       i_serial_clock_pin,
   input  wire logic       i_serial_in_pin,
   input  wire logic       i_select_pin_n,
   output logic            o_serial_clock_pin,
   output logic            o_serial_clock_oe,
   output logic            o_serial_out_pin,
   output logic            o_serial_out_oe,
   output logic            o_port_enable,
   output logic            o_port_irq_flag
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic       input_sample_phase;
   logic       clock_edge_sel;
   logic       write_collision_flag;
   logic       receive_overflow_flag;
   logic       port_enable;
   logic       clock_idle_polarity;
   logic [3:0] port_mode_select;
   logic       buffer_overwrite_enable;
   logic [7:0] baud_divider;
   logic [7:0] data_buffer_reg;
   logic [7:0] shift_reg;
   logic       rx_buffer_full;
   logic       port_irq_flag;
   logic [3:0] bit_cnt;
   logic       busy;
   logic       sdo_bit;
   logic       sck_active;
   logic       phase;
   logic       in_sample;
   logic [7:0] next_shift;
   logic       byte_done;
   logic       wr_data;
   logic       rd_data;
   logic       master;
   logic       sel_ctl;
   logic       sel_active;
   logic       half_tick;
   logic       sck_s;
   logic       sdi_s;
   logic       ss_n_s;
   logic       sck_q;
   role_t      role;
   spi_pins_t  pins;

   assign master  = port_mode_select inside
                    {MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER,
                     MODE_BAUD};                                  // RULE_11
   assign sel_ctl = (port_mode_select == MODE_SLV_SEL);           // RULE_12
   assign role    = master ? ROLE_MASTER : ROLE_SLAVE;
   assign wr_data = i_wr && (i_addr == ADDR_DATA);
   assign rd_data = i_rd && (i_addr == ADDR_DATA);
   // Without select control the slave is always selected
   assign sel_active = !sel_ctl || !ss_n_s;
   // Master data returns on our own clock; the three-stage sync would
   // lag a whole bit at the fastest rate, so master reads the pin itself
   logic sdi_in;
   assign sdi_in = master ? i_serial_in_pin : sdi_s;

   // ----------------------------------------------------------------
   // Pin synchronisers and rate divider
   // ----------------------------------------------------------------
   ssp_pin_sync u_sync_sck (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_pin      (i_serial_clock_pin),
      .o_level    (sck_s)
   );
   ssp_pin_sync u_sync_sdi (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_pin      (i_serial_in_pin),
      .o_level    (sdi_s)
   );
   ssp_pin_sync u_sync_ss (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_pin      (i_select_pin_n),
      .o_level    (ss_n_s)
   );
   ssp_rate_gen u_rate (
      .i_core_clk   (i_core_clk),
      .i_rstn       (i_rstn),
      .i_run        (busy && master),
      .i_mode       (port_mode_select),
      .i_baud       (baud_divider),
      .i_timer_tick (i_timer_tick),
      .o_half_tick  (half_tick)
   );

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         {input_sample_phase, clock_edge_sel} <= RST_STATUS[7:6];
         {port_enable, clock_idle_polarity, port_mode_select}
            <= RST_CONTROL1[5:0];
         buffer_overwrite_enable <= RST_CONTROL3[CON3_BUFFER_OVERWRITE_ENABLE_BIT];
         baud_divider            <= RST_BAUD;
      end else if (i_wr) begin
         case (i_addr)
            ADDR_STATUS: begin
               input_sample_phase <= i_wdata[STAT_SMP_BIT];
               clock_edge_sel     <= i_wdata[STAT_CKE_BIT];
            end
            ADDR_CONTROL1: begin
               port_enable         <= i_wdata[CON1_EN_BIT];
               clock_idle_polarity <= i_wdata[CON1_CKP_BIT];
               port_mode_select    <= i_wdata[3:0];
            end
            ADDR_CONTROL3: begin
               buffer_overwrite_enable <= i_wdata[CON3_BUFFER_OVERWRITE_ENABLE_BIT];
            end
            ADDR_BAUD: baud_divider <= i_wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   // Slave edges are seen on the synchronised clock, leading when it moves off the idle level;
   // in master, phase tracks whether the next edge is leading (idle-to-active) or trailing.
   logic lead_edge;
   logic trail_edge;
   logic slv_edge;
   assign slv_edge = (sck_s != sck_q) && port_enable && !master
                     && sel_active;
   always_comb begin
      lead_edge  = 1'b0;
      trail_edge = 1'b0;
      if (master) begin
         lead_edge  = half_tick && !phase;
         trail_edge = half_tick && phase;
      end else if (slv_edge) begin
         lead_edge  = (sck_s != clock_idle_polarity);
         trail_edge = (sck_s == clock_idle_polarity);
      end
   end

   // Sample on the opposite edge from output change; end-phase in master
   // moves the sample one half bit later, to the next output edge.
   logic samp_edge;
   logic shift_edge;
   always_comb begin
      if (clock_edge_sel) begin                                   // RULE_03
         shift_edge = trail_edge;
         samp_edge  = lead_edge;
      end else begin
         shift_edge = lead_edge;
         samp_edge  = trail_edge;
      end
      if (master && input_sample_phase) begin                     // RULE_01
         samp_edge = shift_edge;
      end
   end

   assign next_shift = {shift_reg[6:0], in_sample};               // RULE_17
   assign byte_done  = busy && (master ? (trail_edge && bit_cnt == 4'h8)
                                       : (samp_edge && bit_cnt == 4'h7));

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         shift_reg  <= 8'h00;
         bit_cnt    <= 4'h0;
         busy       <= 1'b0;
         phase      <= 1'b0;
         in_sample  <= 1'b0;
         sdo_bit    <= 1'b0;
         sck_q      <= 1'b0;
         sck_active <= 1'b0;
      end else if (!port_enable || (sel_ctl && ss_n_s)) begin
         bit_cnt    <= 4'h0;                                      // RULE_22
         busy       <= 1'b0;
         phase      <= 1'b0;
         sck_active <= 1'b0;
         sck_q      <= sck_s;
         if (wr_data && !busy) begin
            shift_reg <= i_wdata;                                 // RULE_20
            sdo_bit   <= i_wdata[7];
         end
      end else begin
         sck_q <= sck_s;
         if (wr_data && !busy) begin
            shift_reg <= i_wdata;                                 // RULE_20
            sdo_bit   <= i_wdata[7];
            busy      <= master;                                  // RULE_21
            bit_cnt   <= 4'h0;
            phase     <= 1'b0;
         end else begin
            if (!master && !busy && samp_edge) begin
               busy <= 1'b1;
            end
            if (master && half_tick) begin
               phase      <= !phase;
               sck_active <= !phase;
            end
            if (samp_edge) begin
               in_sample <= sdi_in;
               bit_cnt   <= bit_cnt + 4'h1;
            end
            if (shift_edge && bit_cnt != 4'h0) begin
               shift_reg <= next_shift;
               sdo_bit   <= shift_reg[6];
            end
            if (byte_done) begin
               busy    <= 1'b0;
               bit_cnt <= 4'h0;
               phase   <= 1'b0;
            end
         end
      end
   end

   // Final byte includes the last sampled bit
   logic [7:0] rx_byte;
   assign rx_byte = {shift_reg[6:0], samp_edge ? sdi_in : in_sample};

   // ----------------------------------------------------------------
   // Receive buffer and status flags
   // ----------------------------------------------------------------
   logic load_ok;
   assign load_ok = !rx_buffer_full || buffer_overwrite_enable;   // RULE_15

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         data_buffer_reg <= 8'h00;
      end else if (wr_data && !busy) begin
         data_buffer_reg <= i_wdata;                              // RULE_20
      end else if (byte_done && load_ok) begin
         data_buffer_reg <= rx_byte;                    // RULE_07 RULE_16
      end
   end

   // Set wins over a same-cycle clear for every flag below
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         rx_buffer_full <= RST_STATUS[STAT_BF_BIT];
      end else if (byte_done) begin
         rx_buffer_full <= 1'b1;                                  // RULE_05
      end else if (rd_data) begin
         rx_buffer_full <= 1'b0;                                  // RULE_05
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         write_collision_flag <= RST_CONTROL1[CON1_WRITE_COLLISION_FLAG_BIT];
      end else if (wr_data && busy) begin
         write_collision_flag <= 1'b1;                            // RULE_06
      end else if (i_wr && i_addr == ADDR_CONTROL1 &&
                   !i_wdata[CON1_WRITE_COLLISION_FLAG_BIT]) begin
         write_collision_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         receive_overflow_flag <= RST_CONTROL1[CON1_OV_BIT];
      end else if (byte_done && rx_buffer_full && !master) begin
         receive_overflow_flag <= 1'b1;         // RULE_07 RULE_08 RULE_16
      end else if (i_wr && i_addr == ADDR_CONTROL1 &&
                   !i_wdata[CON1_OV_BIT]) begin
         receive_overflow_flag <= 1'b0;
      end
   end

   // Interrupt flag held here until software writes zero to it
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         port_irq_flag <= 1'b0;
      end else if (byte_done) begin
         port_irq_flag <= 1'b1;                                   // RULE_17
      end else if (i_wr && i_addr == ADDR_IRQ && !i_wdata[0]) begin
         port_irq_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register read port; shift register has no address
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            // Stop bit always zero in SPI mode, hence when disabled
            ADDR_STATUS:   o_rdata <= {input_sample_phase, clock_edge_sel,
                                       5'h00, rx_buffer_full}; // RULE_10
            ADDR_CONTROL1: o_rdata <= {write_collision_flag,
                                       receive_overflow_flag, port_enable,
                                       clock_idle_polarity,
                                       port_mode_select};
            ADDR_CONTROL3: o_rdata <= {3'h0, buffer_overwrite_enable,
                                       4'h0};
            ADDR_DATA:     o_rdata <= data_buffer_reg;            // RULE_18
            ADDR_BAUD:     o_rdata <= baud_divider;
            ADDR_IRQ:      o_rdata <= {7'h00, port_irq_flag};
            default:       o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always_comb begin
      pins.sck_o  = clock_idle_polarity ^ (sck_active && busy);   // RULE_04
      pins.sck_oe = port_enable && role == ROLE_MASTER;           // RULE_09
      pins.sdo_o  = sdo_bit;
      pins.sdo_oe = port_enable && (master || sel_active);  // RULE_09 RULE_22
   end

   assign o_serial_clock_pin = pins.sck_o;
   assign o_serial_clock_oe  = pins.sck_oe;
   assign o_serial_out_pin   = pins.sdo_o;
   assign o_serial_out_oe    = pins.sdo_oe;
   assign o_port_enable      = port_enable;
   assign o_port_irq_flag    = port_irq_flag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_collision_set: assert property (@(posedge i_core_clk) // RULE_06
      disable iff (!i_rstn) wr_data && busy |=> write_collision_flag)
      else $error("collision flag not set");
   a_no_master_ov: assert property (@(posedge i_core_clk) // RULE_08
      disable iff (!i_rstn) master && $stable(master)
      && !receive_overflow_flag |=> !receive_overflow_flag)
      else $error("overflow set in master mode");
   a_full_on_byte: assert property (@(posedge i_core_clk) // RULE_05
      disable iff (!i_rstn) byte_done |=> rx_buffer_full && port_irq_flag)
      else $error("byte end did not set full");
   a_full_clear: assert property (@(posedge i_core_clk) // RULE_05
      disable iff (!i_rstn) rd_data && !byte_done |=> !rx_buffer_full)
      else $error("read did not clear full");
   a_keep_old: assert property (@(posedge i_core_clk) // RULE_07
      disable iff (!i_rstn) byte_done && rx_buffer_full
      && !buffer_overwrite_enable && !wr_data |=> $stable(data_buffer_reg))
      else $error("buffer overwritten");
   a_overwrite: assert property (@(posedge i_core_clk) // RULE_16
      disable iff (!i_rstn) byte_done && rx_buffer_full && !master
      && buffer_overwrite_enable |=> receive_overflow_flag
      && data_buffer_reg == $past(rx_byte))
      else $error("overwrite path wrong");
   a_idle_level: assert property (@(posedge i_core_clk) // RULE_04
      disable iff (!i_rstn) !busy |-> o_serial_clock_pin == clock_idle_polarity)
      else $error("clock idle level wrong");
   a_sel_float: assert property (@(posedge i_core_clk) // RULE_22
      disable iff (!i_rstn) sel_ctl && ss_n_s |-> !o_serial_out_oe)
      else $error("output driven while deselected");
   a_master_start: assert property (@(posedge i_core_clk) // RULE_21
      disable iff (!i_rstn) wr_data && !busy && master && port_enable
      |=> busy ##1 busy)
      else $error("master did not start");
   a_disabled_pins: assert property (@(posedge i_core_clk) // RULE_09
      disable iff (!i_rstn) !port_enable |-> !o_serial_clock_oe
      && !o_serial_out_oe)
      else $error("pins driven while disabled");

   c_master_byte: cover property (@(posedge i_core_clk)
      disable iff (!i_rstn) byte_done && master);
   c_slave_byte: cover property (@(posedge i_core_clk)
      disable iff (!i_rstn) byte_done && !master);
   c_overflow: cover property (@(posedge i_core_clk)
      disable iff (!i_rstn) $rose(receive_overflow_flag));

endmodule : ssp_spi

/* test/spi_far_end.sv */
// Far-side SPI device: slave to our master, or master to our slave
module spi_far_end (
   input  wire logic i_clk,
   input  wire logic i_sclk,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe,
   output logic      o_sclk,
   output logic      o_sdi,
   output logic      o_sel_n,
   output logic [7:0] o_got
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sr = 8'h00;
   logic       last = 1'b0;
   initial begin
      o_sclk = 1'b0;
      o_sel_n = 1'b1;
      o_sdi = 1'b0;
      o_got = 8'h00;
   end
   // A released data line floats: show the inverse of its last level
   always @(posedge i_clk) begin
      if (i_sdo_oe)
         last <= i_sdo;
   end
   always @(posedge i_sclk) begin
      o_got <= {o_got[6:0], i_sdo_oe ? i_sdo : ~last};
   end
   always @(negedge i_sclk) begin
      sr = {sr[6:0], 1'b0};
      o_sdi = sr[7];
   end
   task automatic load(input logic [7:0] b);
      sr = b;
      o_sdi = b[7];
   endtask : load
   // Slow clock, well under a tenth of the core rate
   task automatic send(input logic [7:0] b);
      load(b);
      o_sel_n = 1'b0;
      repeat (24) @(posedge i_clk);
      for (int i = 0; i < 16; i++) begin
         o_sclk = ~o_sclk;
         repeat (24) @(posedge i_clk);
      end
      o_sel_n = 1'b1;
      repeat (24) @(posedge i_clk);
   endtask : send
endmodule : spi_far_end

/* test/tb_top.sv */
// Self-checking bench for the SPI port
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ssp_spi_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, d, got;
   logic sck, sck_oe, sdo, sdo_oe, en, irq, f_sck, f_sdi, f_sel_n;
   int   n_mismatch = 0, checked = 0, cyc = 0, tcnt = 0;
   wire  sck_line = sck_oe ? sck : f_sck;
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
      tick <= (tcnt == 4);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   ssp_spi ssp_spi_i (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_timer_tick(tick), .i_serial_clock_pin(sck_line),
      .i_serial_in_pin(f_sdi), .i_select_pin_n(f_sel_n),
      .o_serial_clock_pin(sck), .o_serial_clock_oe(sck_oe),
      .o_serial_out_pin(sdo), .o_serial_out_oe(sdo_oe),
      .o_port_enable(en), .o_port_irq_flag(irq));
   spi_far_end spi_far_end_i (.i_clk(clk), .i_sclk(sck_line), .i_sdo(sdo),
      .i_sdo_oe(sdo_oe), .o_sclk(f_sck), .o_sdi(f_sdi), .o_sel_n(f_sel_n),
      .o_got(got));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic put(input logic [2:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : put
   task automatic get(input logic [2:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : get
   task automatic wait_full;
      for (int i = 0; i < 300; i++) begin
         get(ADDR_STATUS);
         if (d[STAT_BF_BIT] === 1'b1)
            break;
      end
   endtask : wait_full
   task automatic gap(output logic [7:0] n);
      logic p;
      p = sck_line;
      n = 8'h00;
      while (sck_line === p && n < 8'hFF) begin
         @(negedge clk);
         n++;
      end
   endtask : gap
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      logic [2:0] ad [5] = '{ADDR_STATUS, ADDR_CONTROL1, ADDR_CONTROL3,
                             ADDR_BAUD, 3'h6};
      logic [7:0] ex [5] = '{RST_STATUS, RST_CONTROL1, RST_CONTROL3,
                             RST_BAUD, 8'h00};
      for (int i = 0; i < 5; i++) begin
         get(ad[i]);
         chk("reset value", d, ex[i]);
      end
      chk("pins idle", {6'h00, sck_oe, sdo_oe}, 8'h00);
   endtask : t_regs
   task automatic t_master;
      logic [3:0] md [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER,
                             MODE_BAUD};
      logic [7:0] hf [5] = '{8'h02, 8'h08, 8'h20, 8'h05, 8'h06};
      logic [7:0] n;
      put(ADDR_CONTROL1, 8'h30);
      @(negedge clk);
      chk("idle high", {6'h00, sck_oe, sck_line}, 8'h03);
      put(ADDR_STATUS, 8'h40);
      put(ADDR_BAUD, 8'h02);
      for (int i = 0; i < 5; i++) begin
         put(ADDR_CONTROL1, {4'h2, md[i]});
         spi_far_end_i.load(8'hC3 ^ 8'(i));
         put(ADDR_DATA, 8'h96 + 8'(i));
         gap(n);
         chk("start", {7'h00, n <= hf[i] + 8'h02}, 8'h01);
         gap(n);
         chk("half bit", n, hf[i]);
         wait_full();
         chk("sent", got, 8'h96 + 8'(i));
         chk("irq", {7'h00, irq}, 8'h01);
         get(ADDR_DATA);
         chk("received", d, 8'hC3 ^ 8'(i));
         get(ADDR_STATUS);
         chk("full clear", d, 8'h40);
         put(ADDR_IRQ, 8'h00);
      end
   endtask : t_master
   task automatic t_collide;
      put(ADDR_DATA, 8'hE1);
      put(ADDR_DATA, 8'h1E);
      wait_full();
      chk("first kept", got, 8'hE1);
      put(ADDR_DATA, 8'h3C);
      for (int i = 0; i < 400 && got !== 8'h3C; i++)
         @(posedge clk);
      // Margin for the last sample to reach the buffer
      repeat (24) @(posedge clk);
      get(ADDR_CONTROL1);
      chk("collision", d, 8'hAA);
      put(ADDR_CONTROL1, 8'h2A);
      get(ADDR_CONTROL1);
      chk("collision clear", d, 8'h2A);
      get(ADDR_DATA);
   endtask : t_collide
   task automatic t_slave;
      put(ADDR_CONTROL1, 8'h00);
      @(negedge clk);
      chk("released", {5'h00, en, sck_oe, sdo_oe}, 8'h00);
      put(ADDR_CONTROL1, 8'h24);
      put(ADDR_STATUS, 8'h40);
      put(ADDR_DATA, 8'h5A);
      @(negedge clk);
      chk("float", {7'h00, sdo_oe}, 8'h00);
      spi_far_end_i.send(8'h81);
      chk("slave sent", got, 8'h5A);
      chk("float after", {7'h00, sdo_oe}, 8'h00);
      spi_far_end_i.send(8'h7E);
      get(ADDR_CONTROL1);
      chk("overflow", d, 8'h64);
      get(ADDR_DATA);
      chk("kept", d, 8'h81);
      put(ADDR_CONTROL1, 8'h24);
      put(ADDR_CONTROL3, 8'h10);
      spi_far_end_i.send(8'h11);
      spi_far_end_i.send(8'h22);
      get(ADDR_CONTROL1);
      chk("overflow again", d, 8'h64);
      get(ADDR_DATA);
      chk("newest", d, 8'h22);
   endtask : t_slave
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_master();
      t_collide();
      t_slave();
      complete_run();
   end
endmodule : tb_top
